// ### hw/sswp_core.sv
// Synchronous 16K x 16 static memory with byte strobes, input latch and tristate data pins
// Contract
// - 16384 words of 16 bits, 14-bit address
// - Address, selects, write captured on rising edge
// - Low strobe bits 0-7, high strobe 8-15
// - Both strobes inactive aborts the write
// - Hold gate high makes input latch transparent
// - Hold gate low keeps captured latch value
// - Selected only when high one, low zero
// - Read drives pins only with enable low
// - Shared data pins; writes never drive
// - Both strobes low writes whole word
// - Low strobe only updates low byte
// - High strobe only updates high byte
// - Pins stay undriven until a read
`timescale 1ns/1ns

module sswp_core
	import sswp_pkg::*;
(
	// Clock and reset
	input  wire logic              CLK_I,
	input  wire logic              RESET_I,
	// Clock-captured controls
	input  wire logic [ADDR_W-1:0] ADDR_I,
	input  wire logic              BANK_PICK_HI_I,
	input  wire logic              BANK_PICK_LO_N_I,
	input  wire logic              WRITE_CMD_N_I,
	// Free-running controls from the controller
	input  wire logic              LANE_LO_STROBE_N_I,
	input  wire logic              LANE_HI_STROBE_N_I,
	input  wire logic              INPUT_HOLD_GATE_I,
	input  wire logic              OUT_DRIVE_EN_N_I,
	// Shared data pins, split into three signals
	input  wire logic [DATA_W-1:0] DATA_IO_I,
	output logic      [DATA_W-1:0] DATA_IO_O,
	output logic                   DATA_IO_OE_O
);

	// ****************************************
	// Captured command
	// ****************************************
	sswp_cmd_t             cmd_ff;       // Command held for the current cycle
	sswp_cmd_t             nxt_cmd;      // Command seen at the pins

	// Select decode and capture on the rising edge only
	assign nxt_cmd.sel  = BANK_PICK_HI_I & ~BANK_PICK_LO_N_I;
	assign nxt_cmd.wr   = ~WRITE_CMD_N_I;
	assign nxt_cmd.addr = ADDR_I;

	// Capture register
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			cmd_ff <= RST_CMD;
		end else begin
			cmd_ff <= nxt_cmd;
		end
	end

	// ****************************************
	// Synchronisers for the free-running pins
	// ****************************************
	logic                  lo_n_m_ff;    // First stage, low strobe
	logic                  lo_n_s_ff;    // Second stage, low strobe
	logic                  hi_n_m_ff;    // First stage, high strobe
	logic                  hi_n_s_ff;    // Second stage, high strobe
	logic                  gate_m_ff;    // First stage, hold gate
	logic                  gate_s_ff;    // Second stage, hold gate
	logic                  oe_n_m_ff;    // First stage, drive enable
	logic                  oe_n_s_ff;    // Second stage, drive enable
	logic [DATA_W-1:0]     din_m_ff;     // First stage, pin data
	logic [DATA_W-1:0]     din_s_ff;     // Second stage, pin data

	// Two flops each; the first stage feeds only the second
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			lo_n_m_ff <= RST_STROBE_N;
			lo_n_s_ff <= RST_STROBE_N;
			hi_n_m_ff <= RST_STROBE_N;
			hi_n_s_ff <= RST_STROBE_N;
			gate_m_ff <= RST_GATE;
			gate_s_ff <= RST_GATE;
			oe_n_m_ff <= RST_OE_N;
			oe_n_s_ff <= RST_OE_N;
			din_m_ff  <= RST_DATA;
			din_s_ff  <= RST_DATA;
		end else begin
			lo_n_m_ff <= LANE_LO_STROBE_N_I;
			lo_n_s_ff <= lo_n_m_ff;
			hi_n_m_ff <= LANE_HI_STROBE_N_I;
			hi_n_s_ff <= hi_n_m_ff;
			gate_m_ff <= INPUT_HOLD_GATE_I;
			gate_s_ff <= gate_m_ff;
			oe_n_m_ff <= OUT_DRIVE_EN_N_I;
			oe_n_s_ff <= oe_n_m_ff;
			din_m_ff  <= DATA_IO_I;
			din_s_ff  <= din_m_ff;
		end
	end

	// ****************************************
	// Input data latch
	// ****************************************
	logic [DATA_W-1:0]     hold_ff;      // Word caught while the gate was high
	logic [DATA_W-1:0]     wr_word;      // Latch output seen by the write path

	// Gate high follows the pins, gate low keeps the last word
	assign wr_word = gate_s_ff ? din_s_ff : hold_ff;

	// Holding register; freezes on the falling gate
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			hold_ff <= RST_DATA;
		end else if (gate_s_ff) begin
			hold_ff <= din_s_ff;
		end
	end

	// ****************************************
	// Cycle decode
	// ****************************************
	logic                  wr_go;        // Selected write cycle
	logic                  rd_go;        // Selected read cycle
	logic                  lo_en;        // Low lane written this edge
	logic                  hi_en;        // High lane written this edge

	// Strobes are the pin levels one edge before the command edge, so a late abort is missed
	assign wr_go = cmd_ff.sel & cmd_ff.wr;
	assign rd_go = cmd_ff.sel & ~cmd_ff.wr;
	assign lo_en = wr_go & ~lo_n_s_ff;
	assign hi_en = wr_go & ~hi_n_s_ff;

	// ****************************************
	// Storage array
	// ****************************************
	logic [DATA_W-1:0]     mem [DEPTH];  // No reset: contents survive reset
	logic [DATA_W-1:0]     mem_word;     // Word at the captured address

	assign mem_word = mem[cmd_ff.addr];

	// Byte-lane writes; lanes are independent
	always_ff @(posedge CLK_I) begin
		if (lo_en) begin
			mem[cmd_ff.addr][LANE_W-1:0] <= wr_word[LANE_W-1:0];
		end
		if (hi_en) begin
			mem[cmd_ff.addr][DATA_W-1:LANE_W] <= wr_word[DATA_W-1:LANE_W];
		end
	end

	// ****************************************
	// Output drivers
	// ****************************************
	logic                  nxt_oe;       // Drive request for the next period

	// Only a selected read with enable low drives; writes and deselects never do
	assign nxt_oe = rd_go & ~oe_n_s_ff;

	// Output registers; reset leaves the pins undriven
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			DATA_IO_O    <= RST_DATA;
			DATA_IO_OE_O <= 1'h0;
		end else begin
			DATA_IO_OE_O <= nxt_oe;
			if (rd_go) begin
				DATA_IO_O <= mem_word;
			end
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	chk_capture_edge: assert property (@(posedge CLK_I) disable iff (RESET_I)
		##1 (cmd_ff.addr == $past(ADDR_I)) && (cmd_ff.wr == !$past(WRITE_CMD_N_I)))
		else $error("captured command differs from pins at edge");

	chk_select_decode: assert property (@(posedge CLK_I) disable iff (RESET_I)
		!$past(BANK_PICK_HI_I) || $past(BANK_PICK_LO_N_I) |-> !cmd_ff.sel)
		else $error("cycle selected with wrong select levels");

	chk_drive_cause: assert property (@(posedge CLK_I) disable iff (RESET_I)
		DATA_IO_OE_O |-> $past(rd_go) && !$past(oe_n_s_ff))
		else $error("pins driven without selected read and enable");

	chk_write_quiet: assert property (@(posedge CLK_I) disable iff (RESET_I)
		wr_go || !cmd_ff.sel |=> !DATA_IO_OE_O)
		else $error("pins driven after write or deselect");

	chk_read_word: assert property (@(posedge CLK_I) disable iff (RESET_I)
		rd_go |=> DATA_IO_O == $past(mem_word))
		else $error("read word does not match array");

	chk_abort_keep: assert property (@(posedge CLK_I) disable iff (RESET_I)
		wr_go && lo_n_s_ff && hi_n_s_ff |=> mem[$past(cmd_ff.addr)] == $past(mem_word))
		else $error("aborted write changed the word");

	chk_full_write: assert property (@(posedge CLK_I) disable iff (RESET_I)
		lo_en && hi_en |=> mem[$past(cmd_ff.addr)] == $past(wr_word))
		else $error("full write did not store latch output");

	chk_low_lane: assert property (@(posedge CLK_I) disable iff (RESET_I)
		lo_en && !hi_en |=> (mem[$past(cmd_ff.addr)][15:8] == $past(mem_word[15:8]))
			&& (mem[$past(cmd_ff.addr)][7:0] == $past(wr_word[7:0])))
		else $error("low lane write wrong");

	chk_high_lane: assert property (@(posedge CLK_I) disable iff (RESET_I)
		hi_en && !lo_en |=> (mem[$past(cmd_ff.addr)][7:0] == $past(mem_word[7:0]))
			&& (mem[$past(cmd_ff.addr)][15:8] == $past(wr_word[15:8])))
		else $error("high lane write wrong");

	chk_latch_hold: assert property (@(posedge CLK_I) disable iff (RESET_I)
		!gate_s_ff |=> hold_ff == $past(hold_ff))
		else $error("latch moved while gate low");

	chk_latch_pass: assert property (@(posedge CLK_I) disable iff (RESET_I)
		gate_s_ff |-> wr_word == $past(DATA_IO_I, 2))
		else $error("latch not transparent while gate high");

endmodule // sswp_core

// ### hw/sswp_pkg.sv
// Constants and carrier types for the synchronous byte-write static memory port
package sswp_pkg;

	// ****************************************
	// Array geometry
	// ****************************************
	localparam int ADDR_W = 14;                 // Registered address width
	localparam int DATA_W = 16;                 // Word width on the data pins
	localparam int LANE_W = 8;                  // Width of one byte lane
	localparam int DEPTH  = 16384;              // Number of stored words

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic       RST_STROBE_N = 1'h1; // Strobes idle inactive
	localparam logic       RST_OE_N     = 1'h1; // Output enable idle off
	localparam logic       RST_GATE     = 1'h0; // Hold gate idle low
	localparam logic [15:0] RST_DATA    = 16'h0000;

	// ****************************************
	// Carrier for the clock-captured command
	// ****************************************
	typedef struct packed {
		logic              sel;   // Bank select decoded true
		logic              wr;    // Write command asserted
		logic [ADDR_W-1:0] addr;  // Captured word address
	} sswp_cmd_t;

	localparam sswp_cmd_t RST_CMD = '{sel: 1'h0, wr: 1'h0, addr: 14'h0000};

endpackage

// ### verification/sswp_ctrl_model.sv
// Controller-side model that drives the memory's control and data pins
`timescale 1ns/1ns

module sswp_ctrl_model
	import sswp_pkg::*;
(
	// Clock and device outputs
	input  wire logic              clk_i,
	input  wire logic [DATA_W-1:0] dev_data_i,
	input  wire logic              dev_oe_i,
	// Controls toward the device
	output logic      [ADDR_W-1:0] addr_o,
	output logic      [1:0]        pick_o,
	output logic                   write_cmd_n_o,
	output logic      [1:0]        strobe_n_o,
	output logic                   hold_gate_o,
	output logic                   drive_en_n_o,
	output logic      [DATA_W-1:0] pin_o
);
	logic              drv  = 1'h0;     // Controller drives the pins
	logic [DATA_W-1:0] wdat = 16'h0000; // Value driven while drv is high
	logic [DATA_W-1:0] last = 16'h0000; // Last resolved pin level

	// Released pins toggle every cycle so a stale word never looks valid
	// An unknown device enable counts as released, so the pattern never turns unknown
	assign pin_o = (dev_oe_i === 1'h1) ? dev_data_i : (drv ? wdat : ~last);

	// Track the resolved level for the toggling pattern
	always @(posedge clk_i) begin
		last <= pin_o;
	end

	// Idle: deselected, strobes and output enable off
	initial begin
		addr_o        = 14'h0000;
		pick_o        = 2'h1;
		write_cmd_n_o = 1'h1;
		strobe_n_o    = 2'h3;
		hold_gate_o   = 1'h0;
		drive_en_n_o  = 1'h1;
	end

	// One memory cycle; async controls settle two edges ahead of the command, four when lat holds the latch
	task automatic run(input logic [1:0] pk, input logic [ADDR_W-1:0] a, input logic wn,
		input logic [1:0] sn, input logic [DATA_W-1:0] d, input logic lat, input logic oen);
		@(negedge clk_i);
		strobe_n_o   = sn;
		drive_en_n_o = oen;
		hold_gate_o  = 1'h1;
		drv          = ~wn;
		wdat         = d;
		if (lat) begin
			@(negedge clk_i);
			hold_gate_o = 1'h0;
			@(negedge clk_i);
			wdat = ~d;
		end
		repeat (2) @(negedge clk_i);
		addr_o        = a;
		pick_o        = pk;
		write_cmd_n_o = wn;
		@(negedge clk_i);
		addr_o        = ~a;
		pick_o        = 2'h1;
		write_cmd_n_o = 1'h1;
		repeat (3) @(negedge clk_i);
		strobe_n_o = 2'h3;
		drv        = 1'h0;
	endtask
endmodule // sswp_ctrl_model

// ### verification/tb_top.sv
// Self-checking bench for the byte-write static memory port
`timescale 1ns/1ns

module tb_top;
	import sswp_pkg::*;
	logic              clk = 1'h0;         // Device clock
	logic              rst = 1'h1;         // Synchronous reset
	logic [ADDR_W-1:0] addr;               // Command address
	logic [1:0]        pick, stb_n;        // Bank selects, byte strobes
	logic              cmd_n, gate, oe_n;  // Write command, hold gate, drive enable
	logic              dev_oe;             // Device drives pins
	logic [DATA_W-1:0] pin, dev_do;        // Pin level, device read word
	logic [DATA_W-1:0] ref_m [DEPTH];      // Expected array contents
	logic [DATA_W-1:0] exp_q [$];          // Expected read words
	logic [ADDR_W-1:0] used [4];           // Addresses in play
	int                fail_count = 0;
	int                checks = 0;
	logic [31:0]       seed = 32'h0001441e;

	initial forever #2 clk = ~clk;

	sswp_core u_dut (.CLK_I(clk), .RESET_I(rst), .ADDR_I(addr), .BANK_PICK_HI_I(pick[1]),
		.BANK_PICK_LO_N_I(pick[0]), .WRITE_CMD_N_I(cmd_n), .LANE_LO_STROBE_N_I(stb_n[0]),
		.LANE_HI_STROBE_N_I(stb_n[1]), .INPUT_HOLD_GATE_I(gate), .OUT_DRIVE_EN_N_I(oe_n),
		.DATA_IO_I(pin), .DATA_IO_O(dev_do), .DATA_IO_OE_O(dev_oe));
	sswp_ctrl_model u_ctrl (.clk_i(clk), .dev_data_i(dev_do), .dev_oe_i(dev_oe), .addr_o(addr),
		.pick_o(pick), .write_cmd_n_o(cmd_n), .strobe_n_o(stb_n), .hold_gate_o(gate),
		.drive_en_n_o(oe_n), .pin_o(pin));

	// Xorshift source with a fixed start
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// Compare and count
	task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] want);
		checks++;
		if (seen !== want) begin
			fail_count++;
			$display("CHECK FAILED at %0t: saw %h want %h", $time, seen, want);
		end
	endtask

	// Note the expected effect, then let the controller run the cycle
	task automatic op(input logic [1:0] pk, input logic [ADDR_W-1:0] a, input logic wn,
		input logic [1:0] sn, input logic [DATA_W-1:0] d, input logic lat, input logic oen);
		if (pk == 2'h2 && !wn && !sn[0]) ref_m[a][7:0] = d[7:0];
		if (pk == 2'h2 && !wn && !sn[1]) ref_m[a][15:8] = d[15:8];
		if (pk == 2'h2 && wn && !oen) exp_q.push_back(ref_m[a]);
		u_ctrl.run(pk, a, wn, sn, d, lat, oen);
		check(16'(exp_q.size()), 16'h0000);
	endtask

	// Every driven read takes the oldest note; unexpected drive mismatches
	always @(negedge clk) begin
		if (rst && $time > 8)
			check(16'(dev_oe), 16'h0000);
		else if (!rst && dev_oe !== 1'h0) begin
			// A drive with nothing noted is a mismatch even if the word is unknown
			if (exp_q.size() > 0)
				check(dev_do, exp_q.pop_front());
			else
				check(16'(dev_oe), 16'h0000);
		end
	end

	// Verdict and end of run
	task automatic stop_test();
		$display("Counts: %0d comparisons, %0d mismatches", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Hang guard
	initial begin
		repeat (20000) @(posedge clk);
		check(16'h0001, 16'h0000);
		stop_test();
	end

	// Main sequence
	initial begin
		repeat (6) @(negedge clk);
		rst = 1'h0;
		used = '{14'h0000, 14'h3fff, 14'(rnd()), 14'(rnd())};
		foreach (used[i]) op(2'h2, used[i], 1'h0, 2'h0, 16'(rnd()), 1'h0, 1'h0);
		foreach (used[i]) op(2'h2, used[i], 1'h1, 2'h3, 16'h0000, 1'h0, 1'h0);
		$display("test full_words done");
		op(2'h2, used[0], 1'h0, 2'h2, 16'h1234, 1'h0, 1'h0);
		op(2'h2, used[0], 1'h0, 2'h1, 16'habcd, 1'h1, 1'h0);
		op(2'h2, used[0], 1'h0, 2'h3, 16'h5555, 1'h0, 1'h0);
		op(2'h2, used[0], 1'h1, 2'h3, 16'h0000, 1'h0, 1'h0);
		$display("test lanes done");
		for (int k = 0; k < 4; k++) begin
			op(2'(k), used[1], 1'h0, 2'h0, 16'hdead, 1'h0, 1'h0);
			op(2'(k), used[1], 1'h1, 2'h3, 16'h0000, 1'h0, 1'h0);
		end
		op(2'h2, used[1], 1'h1, 2'h3, 16'h0000, 1'h0, 1'h1);
		$display("test select done");
		repeat (40) begin
			op(2'(rnd()), used[2'(rnd())], 1'(rnd()), 2'(rnd()), 16'(rnd()), 1'(rnd()), 1'(rnd()));
		end
		$display("test random_mix done");
		stop_test();
	end
endmodule // tb_top
